// ===== rtl/pvdt_regs.svh
// Offsets, field positions, reset values and timing counts of the phase timer.
// Assumes a 100 MHz clk_sys and a 16-bit register port.
`ifndef PVDT_REGS_SVH
`define PVDT_REGS_SVH

// ==========================================================================
// Timing
`define PVDT_CLK_MHZ          100
`define PVDT_TICK_MS          100
`define PVDT_TICK_CYCLES      (`PVDT_TICK_MS * 1000 * `PVDT_CLK_MHZ)
`define PVDT_FLASH_TENTHS     14'h0005

// ==========================================================================
// Register offsets (word index on the register port)
`define PVDT_R_MIN_GREEN      5'h00
`define PVDT_R_PASSAGE        5'h01
`define PVDT_R_MAX1           5'h02
`define PVDT_R_MAX2           5'h03
`define PVDT_R_YELLOW         5'h04
`define PVDT_R_RED_CLR        5'h05
`define PVDT_R_WALK           5'h06
`define PVDT_R_PED_CLR        5'h07
`define PVDT_R_RED_REVERT     5'h08
`define PVDT_R_UNIT_REVERT    5'h09
`define PVDT_R_ADDED_INIT     5'h0A
`define PVDT_R_MAX_INIT       5'h0B
`define PVDT_R_RED_DELAY_SEC  5'h0C
`define PVDT_R_VEH_THRESHOLD  5'h0D
`define PVDT_R_RED_PERIOD     5'h0E
`define PVDT_R_MIN_GAP        5'h0F
`define PVDT_R_CTRL           5'h10
`define PVDT_R_STATUS         5'h11
`define PVDT_R_LIVE_GAP       5'h12
`define PVDT_NUM_CFG          17

// ==========================================================================
// Control fields
`define PVDT_C_MAX2_PHASE     0
`define PVDT_C_MAX2_PATTERN   1
`define PVDT_C_OVERLAP        2
`define PVDT_C_REST_WALK      3
`define PVDT_C_INIT_EN_LO     8
`define PVDT_C_INIT_EN_HI     11

// ==========================================================================
// Reset value of every setting
`define PVDT_RST_CFG          16'h0000

`endif

// ===== rtl/pvdt_pkg.sv
// Types shared by the phase interval timer.
// Assumes the constants of pvdt_regs.svh.
package pvdt_pkg;

  // Vehicle interval of the phase
  typedef enum logic [1:0] {
    PVDT_RED_REST,
    PVDT_GREEN,
    PVDT_YELLOW,
    PVDT_ALL_RED
  } pvdt_veh_type;

  // Pedestrian interval of the phase
  typedef enum logic [1:0] {
    PVDT_DONT_WALK,
    PVDT_WALK,
    PVDT_PED_CLEAR
  } pvdt_ped_type;

  // Signal head drive
  typedef struct packed {
    logic green;
    logic yellow;
    logic red;
    logic walk;
    logic dont_walk;
  } pvdt_lamp_type;

endpackage

// ===== rtl/pvdt_phase_timing.sv
// Interval timing of one traffic phase: initial green, gap reduction, max,
// clearances, red revert and the pedestrian sequence.
// Assumes field inputs are asynchronous pins and registers are written by a
// local master on clk_sys.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "pvdt_regs.svh"

module pvdt_phase_timing #(
  parameter int unsigned TICK_CYCLES = `PVDT_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  // Register port
  input  wire logic [4:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [15:0]                reg_rdata,
  // Field inputs
  input  wire logic [3:0]            det_act,
  input  wire logic                  ped_call,
  input  wire logic                  conflict_call,
  input  wire logic                  conflict_check,
  input  wire logic                  coord_mode,
  input  wire logic                  force_off,
  input  wire logic                  max2_ring,
  // Indications
  output pvdt_pkg::pvdt_lamp_type    lamps,
  output logic                       max_out,
  output logic                       gap_out
);

  // ========================================================================
  // Helpers
  // Seconds to tenths
  function automatic logic [13:0] to_tenths(input logic [9:0] s);
    to_tenths = {1'b0, s, 3'b000} + {3'b000, s, 1'b0};
  endfunction

  // Tenths setting widened
  function automatic logic [13:0] tenths8(input logic [15:0] r);
    tenths8 = {6'h00, r[7:0]};
  endfunction

  // Number of detectors in a set
  function automatic logic [2:0] count_ones(input logic [3:0] v);
    count_ones = 3'({2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]});
  endfunction

  // ========================================================================
  // Reset release
  logic rst_m_q;
  logic rst_s_q;
  wire  rst_n = rst_s_q;

  // Two-stage reset synchroniser
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // ========================================================================
  // Pin synchronisers
  wire  [9:0] pin_raw = {max2_ring, force_off, coord_mode, conflict_check,
                         conflict_call, ped_call, det_act};
  logic [9:0] pin_m_q;
  logic [9:0] pin_s_q;
  logic [3:0] det_prev_q;
  logic       ped_prev_q;
  logic       cc_prev_q;

  // Two flops per pin, then edge history
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_m_q    <= 10'h000;
      pin_s_q    <= 10'h000;
      det_prev_q <= 4'h0;
      ped_prev_q <= 1'b0;
      cc_prev_q  <= 1'b0;
    end else begin
      pin_m_q    <= pin_raw;
      pin_s_q    <= pin_m_q;
      det_prev_q <= pin_s_q[3:0];
      ped_prev_q <= pin_s_q[4];
      cc_prev_q  <= pin_s_q[5];
    end
  end

  // Synchronised field levels
  wire [3:0] det     = pin_s_q[3:0];
  wire       ped     = pin_s_q[4];
  wire       cc      = pin_s_q[5];
  wire       cchk    = pin_s_q[6];
  wire       coord   = pin_s_q[7];
  wire       fo      = pin_s_q[8];
  wire       mx2_in  = pin_s_q[9];
  wire [3:0] det_edg = det & ~det_prev_q;
  wire       ped_edg = ped & ~ped_prev_q;
  wire       cc_fall = cc_prev_q & ~cc;

  // ========================================================================
  // Tenth-second tick
  logic [23:0] tick_cnt_q;
  logic        tick_q;

  // Common time base for every interval
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_q <= 24'h000000;
      tick_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == 24'(TICK_CYCLES - 1));
      tick_cnt_q <= (tick_cnt_q == 24'(TICK_CYCLES - 1)) ? 24'h000000 : tick_cnt_q + 24'h000001;
    end
  end

  // ========================================================================
  // Settings
  logic [15:0] cfg_q [0:`PVDT_NUM_CFG-1];
  wire         cfg_hit = reg_wr && (reg_addr <= `PVDT_R_CTRL);

  // Register writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < `PVDT_NUM_CFG; i++) begin
        cfg_q[i] <= `PVDT_RST_CFG;
      end
    end else if (cfg_hit) begin
      cfg_q[reg_addr] <= reg_wdata;
    end
  end

  // Scaled settings, all times in tenths
  wire [15:0] ctrl    = cfg_q[`PVDT_R_CTRL];
  wire [3:0]  ie_mask = ctrl[`PVDT_C_INIT_EN_HI:`PVDT_C_INIT_EN_LO];
  wire        overlap = ctrl[`PVDT_C_OVERLAP];
  wire        rest_wk = ctrl[`PVDT_C_REST_WALK];
  wire [13:0] min_g   = to_tenths({2'b00, cfg_q[`PVDT_R_MIN_GREEN][7:0]});
  wire [13:0] pass_g  = tenths8(cfg_q[`PVDT_R_PASSAGE]);
  wire        use_mx2 = mx2_in | ctrl[`PVDT_C_MAX2_PATTERN] | ctrl[`PVDT_C_MAX2_PHASE];
  wire [13:0] max_g   = to_tenths(use_mx2 ? cfg_q[`PVDT_R_MAX2][9:0] : cfg_q[`PVDT_R_MAX1][9:0]);
  wire [13:0] yel_g   = tenths8(cfg_q[`PVDT_R_YELLOW]);
  wire [13:0] red_g   = tenths8(cfg_q[`PVDT_R_RED_CLR]);
  wire [13:0] walk_g  = to_tenths({2'b00, cfg_q[`PVDT_R_WALK][7:0]});
  wire [13:0] pclr_g  = to_tenths({2'b00, cfg_q[`PVDT_R_PED_CLR][7:0]});
  wire [13:0] rrv_ph  = tenths8(cfg_q[`PVDT_R_RED_REVERT]);
  wire [13:0] rrv_un  = tenths8(cfg_q[`PVDT_R_UNIT_REVERT]);
  wire [13:0] rrev_g  = (rrv_ph > rrv_un) ? rrv_ph : rrv_un;
  wire [7:0]  add_i   = cfg_q[`PVDT_R_ADDED_INIT][7:0];
  wire [13:0] maxi_g  = to_tenths({2'b00, cfg_q[`PVDT_R_MAX_INIT][7:0]});
  wire [13:0] tbr_g   = to_tenths({2'b00, cfg_q[`PVDT_R_RED_DELAY_SEC][7:0]});
  wire [7:0]  reduction_delay_count     = cfg_q[`PVDT_R_VEH_THRESHOLD][7:0];
  wire [13:0] ttr_g   = to_tenths({2'b00, cfg_q[`PVDT_R_RED_PERIOD][7:0]});
  wire [13:0] mgap_g  = tenths8(cfg_q[`PVDT_R_MIN_GAP]);

  // ========================================================================
  // Interval state
  pvdt_pkg::pvdt_veh_type veh_q;
  pvdt_pkg::pvdt_veh_type veh_d;
  pvdt_pkg::pvdt_ped_type ped_q;
  pvdt_pkg::pvdt_ped_type ped_d;
  logic [13:0]            vt_q;
  logic [13:0]            pt_q;
  wire  in_green   = (veh_q == pvdt_pkg::PVDT_GREEN);
  wire  in_clear   = ~in_green;
  wire  leave_grn  = in_green && (veh_d == pvdt_pkg::PVDT_YELLOW);

  // ========================================================================
  // Variable initial
  logic [13:0] ext_q;
  logic [8:0]  car_q;
  logic [3:0]  called_q;
  wire  [3:0]  ie_edg  = det_edg & ie_mask;
  wire  [2:0]  n_ie    = count_ones(ie_edg);
  wire         ie_any  = |(called_q & ie_mask);
  wire         vd_off  = (maxi_g <= min_g) || (add_i == 8'h00) || !ie_any;
  wire  [13:0] tac     = min_g + ext_q;
  wire  [13:0] tac_lim = (tac > maxi_g) ? maxi_g : tac;
  wire  [13:0] init_g  = (vd_off || tac_lim < min_g) ? min_g : tac_lim;
  wire         min_done = in_green && (vt_q >= init_g);

  // Actuations in yellow and red build the extension and the car count
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_q    <= 14'h0000;
      car_q    <= 9'h000;
      called_q <= 4'h0;
    end else if (leave_grn) begin
      ext_q    <= 14'h0000;
      car_q    <= 9'h000;
      called_q <= 4'h0;
    end else if (in_clear) begin
      called_q <= called_q | det_edg;
      if (ext_q < maxi_g) begin
        ext_q <= ext_q + 14'({6'h00, add_i} * {11'h000, n_ie});
      end
      if (car_q < 9'h1F0) begin
        car_q <= car_q + {6'h00, n_ie};
      end
    end
  end

  // ========================================================================
  // Gap reduction
  logic [13:0] tbr_q;
  logic [13:0] ttr_q;
  logic [13:0] gap_q;
  wire         red_on  = in_green && cc && ((tbr_q >= tbr_g) || (car_q > {1'b0, reduction_delay_count}));
  wire  [13:0] diff    = (pass_g > mgap_g) ? pass_g - mgap_g : 14'h0000;
  wire  [27:0] red_prd = diff * ttr_q;
  wire  [27:0] red_quo = red_prd / {14'h0000, ttr_g};
  wire  [13:0] red_amt = !red_on ? 14'h0000 : (ttr_g == 14'h0000) ? diff : red_quo[13:0];
  wire  [13:0] cur_gap = pass_g - red_amt;
  wire         gapped  = (gap_q == 14'h0000) && (det == 4'h0);

  // Delay and period counters follow the conflicting call
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tbr_q <= 14'h0000;
      ttr_q <= 14'h0000;
    end else if (!in_green || !cc) begin
      tbr_q <= 14'h0000;
      ttr_q <= 14'h0000;
    end else if (tick_q) begin
      if (tbr_q < tbr_g) begin
        tbr_q <= tbr_q + 14'h0001;
      end
      if (red_on && ttr_q < ttr_g) begin
        ttr_q <= ttr_q + 14'h0001;
      end
    end
  end

  // Passage timer: reload on actuation, count down after it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 14'h0000;
    end else if (cc_fall) begin
      gap_q <= pass_g;
    end else if (!in_green || det != 4'h0) begin
      gap_q <= cur_gap;
    end else if (tick_q && gap_q != 14'h0000) begin
      gap_q <= gap_q - 14'h0001;
    end
  end

  // ========================================================================
  // Maximum green
  logic        max_run_q;
  logic [13:0] max_q;
  wire         maxed = max_run_q && (max_q >= max_g);

  // Starts on the first conflicting call of the green
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      max_run_q <= 1'b0;
      max_q     <= 14'h0000;
    end else if (!in_green) begin
      max_run_q <= 1'b0;
      max_q     <= 14'h0000;
    end else begin
      max_run_q <= max_run_q | cc;
      if (max_run_q && tick_q && max_q < max_g) begin
        max_q <= max_q + 14'h0001;
      end
    end
  end

  // ========================================================================
  // Vehicle intervals
  logic call_q;
  wire  ped_ok = (ped_q == pvdt_pkg::PVDT_DONT_WALK) ||
                 (overlap && ped_q == pvdt_pkg::PVDT_PED_CLEAR);
  wire  term   = coord ? fo : (cc && min_done && (gapped || maxed));

  // Next vehicle interval
  always_comb begin
    veh_d = veh_q;
    unique case (veh_q)
      pvdt_pkg::PVDT_GREEN: begin
        if (term && ped_ok) veh_d = pvdt_pkg::PVDT_YELLOW;
      end
      pvdt_pkg::PVDT_YELLOW: begin
        if (vt_q >= yel_g) veh_d = pvdt_pkg::PVDT_ALL_RED;
      end
      pvdt_pkg::PVDT_ALL_RED: begin
        if (vt_q >= red_g) veh_d = pvdt_pkg::PVDT_RED_REST;
      end
      pvdt_pkg::PVDT_RED_REST: begin
        if (call_q && vt_q >= rrev_g) veh_d = pvdt_pkg::PVDT_GREEN;
      end
    endcase
  end

  // Interval register, elapsed time and phase call memory
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      veh_q  <= pvdt_pkg::PVDT_RED_REST;
      vt_q   <= 14'h0000;
      call_q <= 1'b0;
    end else begin
      veh_q  <= veh_d;
      vt_q   <= (veh_d != veh_q) ? 14'h0000 : (tick_q && vt_q != 14'h3FFF) ? vt_q + 14'h0001 : vt_q;
      call_q <= in_green ? 1'b0 : (call_q | (det_edg != 4'h0) | ped_edg);
    end
  end

  // ========================================================================
  // Pedestrian intervals
  logic pc_q;
  logic served_q;
  logic fl_q;
  logic [13:0] flc_q;
  wire  ped_go  = in_green && pc_q && (!served_q || (!cc && !cchk));
  wire  hold_wk = rest_wk && !coord && !cc;
  wire  ped_end = (coord && fo) || (veh_q == pvdt_pkg::PVDT_ALL_RED);

  // Next pedestrian interval, timed beside the vehicle intervals
  always_comb begin
    ped_d = ped_q;
    unique case (ped_q)
      pvdt_pkg::PVDT_DONT_WALK: begin
        if (ped_go) ped_d = pvdt_pkg::PVDT_WALK;
      end
      pvdt_pkg::PVDT_WALK: begin
        if (ped_end) ped_d = pvdt_pkg::PVDT_DONT_WALK;
        else if (pt_q >= walk_g && !hold_wk) ped_d = pvdt_pkg::PVDT_PED_CLEAR;
      end
      default: begin
        if (ped_end || pt_q >= pclr_g) ped_d = pvdt_pkg::PVDT_DONT_WALK;
      end
    endcase
  end

  // Pedestrian register, elapsed time, call memory and flasher
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ped_q    <= pvdt_pkg::PVDT_DONT_WALK;
      pt_q     <= 14'h0000;
      pc_q     <= 1'b0;
      served_q <= 1'b0;
      fl_q     <= 1'b0;
      flc_q    <= 14'h0000;
    end else begin
      ped_q    <= ped_d;
      pt_q     <= (ped_d != ped_q) ? 14'h0000 : (tick_q && pt_q != 14'h3FFF) ? pt_q + 14'h0001 : pt_q;
      pc_q     <= ped_edg | (pc_q & ~ped_go); // New call wins over clear
      served_q <= in_green & (served_q | ped_go);
      if (ped_q != pvdt_pkg::PVDT_PED_CLEAR) begin
        fl_q  <= 1'b1;
        flc_q <= 14'h0000;
      end else if (tick_q) begin
        fl_q  <= (flc_q == `PVDT_FLASH_TENTHS - 14'h0001) ? ~fl_q : fl_q;
        flc_q <= (flc_q == `PVDT_FLASH_TENTHS - 14'h0001) ? 14'h0000 : flc_q + 14'h0001;
      end
    end
  end

  // ========================================================================
  // Outputs and read port
  wire [15:0] status = {8'h00, gapped, maxed, red_on, min_done,
                        2'(ped_q), 2'(veh_q)};
  wire [15:0] rd_val = (reg_addr <= `PVDT_R_CTRL)      ? cfg_q[reg_addr] :
                       (reg_addr == `PVDT_R_STATUS)    ? status :
                       (reg_addr == `PVDT_R_LIVE_GAP)  ? {2'b00, cur_gap} : 16'h0000;

  // Registered indications and read data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lamps     <= '0;
      max_out   <= 1'b0;
      gap_out   <= 1'b0;
      reg_rdata <= 16'h0000;
    end else begin
      lamps.green     <= in_green;
      lamps.yellow    <= (veh_q == pvdt_pkg::PVDT_YELLOW);
      lamps.red       <= (veh_q == pvdt_pkg::PVDT_ALL_RED) || (veh_q == pvdt_pkg::PVDT_RED_REST);
      lamps.walk      <= (ped_q == pvdt_pkg::PVDT_WALK);
      lamps.dont_walk <= (ped_q == pvdt_pkg::PVDT_DONT_WALK) ||
                         (ped_q == pvdt_pkg::PVDT_PED_CLEAR && fl_q);
      max_out   <= in_green && maxed;
      gap_out   <= min_done && gapped;
      reg_rdata <= reg_rd ? rd_val : 16'h0000;
    end
  end

endmodule // pvdt_phase_timing

// ===== verif/pvdt_phase_monitor.sv
// Checker of the phase timer's port behaviour.
// Assumes binding to pvdt_phase_timing on a single clk_sys domain.
`timescale 1ns/1ps
`include "pvdt_regs.svh"

module pvdt_phase_monitor #(
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic                    clk_sys,
  input wire logic                    nrst,
  // Register port
  input wire logic [4:0]              reg_addr,
  input wire logic [15:0]             reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [15:0]             reg_rdata,
  // Field side
  input wire logic [3:0]              det_act,
  input wire pvdt_pkg::pvdt_lamp_type lamps,
  input wire logic                    max_out,
  input wire logic                    gap_out
);
  int unsigned yel_q;
  int unsigned ycnt_q;
  int unsigned y_exp;
  logic        ovl_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // Shadow the yellow length and the overlap option as written
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      yel_q <= 0;
      ovl_q <= 1'b0;
    end else if (reg_wr && reg_addr == `PVDT_R_YELLOW) begin
      yel_q <= 32'(reg_wdata[7:0]);
    end else if (reg_wr && reg_addr == `PVDT_R_CTRL) begin
      ovl_q <= reg_wdata[`PVDT_C_OVERLAP];
    end
  end

  // Length of the running yellow in clocks
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ycnt_q <= 0;
    end else begin
      ycnt_q <= lamps.yellow ? ycnt_q + 1 : 0;
    end
  end

  assign y_exp = yel_q * TICK_CYCLES;

  rdata_idle_a: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
    else $error("read data outside answer cycle");
  head_excl_a: assert property ($onehot0({lamps.green, lamps.yellow, lamps.red}))
    else $error("more than one vehicle lamp");
  yel_entry_a: assert property ($rose(lamps.yellow) |-> $past(lamps.green))
    else $error("yellow not after green");
  red_after_a: assert property ($fell(lamps.yellow) |-> lamps.red && !lamps.green)
    else $error("yellow not followed by red");
  yel_len_a: assert property ($fell(lamps.yellow) |-> ycnt_q + TICK_CYCLES + 2 >= y_exp &&
    ycnt_q <= y_exp + TICK_CYCLES + 2) else $error("yellow length wrong");
  grn_entry_a: assert property ($rose(lamps.green) |-> $past(lamps.red))
    else $error("green not from red");
  ped_excl_a: assert property (!(lamps.walk && lamps.dont_walk))
    else $error("walk and dont walk together");
  walk_grn_a: assert property (lamps.walk |-> lamps.green)
    else $error("walk outside green");
  ovl_hold_a: assert property (lamps.yellow && !ovl_q |-> lamps.dont_walk && !lamps.walk)
    else $error("ped clearance runs into yellow");
  max_grn_a: assert property (max_out |-> !lamps.red)
    else $error("max out outside green");
  act_gap_a: assert property ((det_act != 4'h0) [*5] |-> !gap_out)
    else $error("gap out with actuation present");

  c_yel_c: cover property ($rose(lamps.yellow));
  c_walk_c: cover property ($rose(lamps.walk));
  c_max_c: cover property ($rose(max_out));
  c_gap_c: cover property ($rose(gap_out));
endmodule // pvdt_phase_monitor

bind pvdt_phase_timing pvdt_phase_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (.clk_sys(clk_sys), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .det_act(det_act), .lamps(lamps), .max_out(max_out), .gap_out(gap_out));

// ===== verif/pvdt_field_model.sv
// Detectors, push-button and conflicting demand seen by the phase.
// Assumes the caller runs its tasks off the clock edge.
`timescale 1ns/1ps

module pvdt_field_model (
  // Clock
  input wire logic   clk_sys,
  // Field pins
  output logic [3:0] det_act,
  output logic       ped_call,
  output logic       conflict_call,
  output logic       max2_ring
);
  // Idle field: no presence, no demand
  initial begin
    det_act = 4'h0;
    ped_call = 1'b0;
    conflict_call = 1'b0;
    max2_ring = 1'b0;
  end

  // Separate actuations long enough to pass the synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_sys) det_act <= 4'h1;
      repeat (3) @(posedge clk_sys);
      det_act <= 4'h0;
      repeat (3) @(posedge clk_sys);
    end
  endtask

  // Standing presence holds the green extensible
  task automatic hold(input logic b);
    @(posedge clk_sys) det_act <= {3'h0, b};
  endtask

  // Push-button press
  task automatic ped_press();
    @(posedge clk_sys) ped_call <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ped_call <= 1'b0;
  endtask

  // Conflicting demand and ring max select
  task automatic set(input logic c, input logic m);
    @(posedge clk_sys) conflict_call <= c;
    max2_ring <= m;
  endtask
endmodule // pvdt_field_model

// ===== verif/tb_top.sv
// Self-checking bench of the phase timer.
// Assumes a short tick parameter so each tenth-second tick lasts four clocks.
`timescale 1ns/1ps
`include "pvdt_regs.svh"

module tb_top;
  localparam int unsigned TICK = 4;
  logic clk_sys, nrst, reg_wr, reg_rd, ped_call, conflict_call, max2_ring, max_out, gap_out;
  logic conflict_check, coord_mode, force_off;
  logic [4:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [3:0]  det_act;
  logic [15:0] cfg [16];
  pvdt_pkg::pvdt_lamp_type lamps;
  int n_fail, n_compared, cyc;

  pvdt_phase_timing #(.TICK_CYCLES(TICK)) uut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .det_act(det_act),
    .ped_call(ped_call), .conflict_call(conflict_call), .conflict_check(conflict_check),
    .coord_mode(coord_mode), .force_off(force_off), .max2_ring(max2_ring), .lamps(lamps),
    .max_out(max_out), .gap_out(gap_out));
  pvdt_field_model fm (.clk_sys(clk_sys), .det_act(det_act), .ped_call(ped_call),
    .conflict_call(conflict_call), .max2_ring(max2_ring));

  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end

  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Within three ticks of the expected clock count
  function automatic logic near(input int got, input int exp);
    return (got + 3 * TICK >= exp) && (got <= exp + 3 * TICK);
  endfunction

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask

  // One service of the phase; returns when green ends
  task automatic serve(input logic [15:0] ctrl, input int acts, input logic hld, input logic ped,
                       input int ticks);
    int t, n, fl, wk;
    logic mx, gp, pdw;
    t = 0;
    n = 0;
    fl = 0;
    wk = 0;
    mx = 1'b0;
    gp = 1'b0;
    wr(`PVDT_R_CTRL, ctrl);
    fm.pulses(acts);
    if (ped) fm.ped_press();
    fm.hold(hld);
    while (lamps.green !== 1'b1 && t < 400) begin
      @(posedge clk_sys);
      #1 t++;
    end
    pdw = lamps.dont_walk;
    while (lamps.green === 1'b1 && n < 400) begin
      @(posedge clk_sys);
      #1 n++;
      mx |= max_out;
      gp |= gap_out;
      wk += (lamps.walk === 1'b1);
      fl += (lamps.dont_walk === 1'b1 && pdw === 1'b0);
      pdw = lamps.dont_walk;
    end
    fm.hold(1'b0);
    check(16'(near(n, ticks * TICK)), 16'h0001);
    check({14'h0, mx, gp}, {14'h0, hld, !hld});
    if (ped) check(16'(near(wk, 10 * TICK)), 16'h0001);
    if (!ctrl[`PVDT_C_OVERLAP]) check(16'(fl >= 2), 16'(ped));
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    conflict_check = 1'b0;
    coord_mode = 1'b0;
    force_off = 1'b0;
    n_fail = 0;
    n_compared = 0;
    cyc = 0;
    cfg = '{16'h0001, 16'h0005, 16'h0003, 16'h0002, 16'h0003, 16'h0002, 16'h0001, 16'h0002,
            16'h0004, 16'h0002, 16'h0005, 16'h0002, 16'h0001, 16'h0002, 16'h0001, 16'h0002};
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 19; i++) rd(5'(i), (i == `PVDT_R_STATUS) ? 16'h0080 : 16'h0000);
    for (int i = 0; i < 16; i++) wr(5'(i), cfg[i]);
    for (int i = 0; i < 16; i++) rd(5'(i), cfg[i]);
    wr(5'h1F, 16'hFFFF);
    rd(5'h1F, 16'h0000);
    fm.set(1'b1, 1'b0);
    serve(16'h0000, 1, 1'b0, 1'b0, 10);
    serve(16'h0100, 3, 1'b0, 1'b0, 20);
    serve(16'h0000, 3, 1'b0, 1'b0, 10);
    serve(16'h0000, 1, 1'b1, 1'b0, 30);
    serve(16'h0001, 1, 1'b1, 1'b0, 20);
    fm.set(1'b1, 1'b1);
    serve(16'h0000, 1, 1'b1, 1'b0, 20);
    fm.set(1'b1, 1'b0);
    // Max well past the ped service so only the gap ends these greens
    wr(`PVDT_R_MAX1, 16'h0005);
    serve(16'h0000, 0, 1'b0, 1'b1, 30);
    serve(16'h0004, 0, 1'b0, 1'b1, 10);
    // Coordinated: force-off ends green and the ped clearance together
    coord_mode <= 1'b1;
    fork
      serve(16'h0004, 0, 1'b0, 1'b1, 16);
      begin
        wait (lamps.green === 1'b1);
        repeat (60) @(posedge clk_sys);
        force_off <= 1'b1;
      end
    join
    force_off <= 1'b0;
    conclude();
  end
endmodule // tb_top
